// *** pin_mux_asserts.sv ***
// Concurrent checks on the function select block's bus and pin ports
`timescale 1ns/1ps
`include "pin_mux_defs.vh"
module pin_mux_asserts (
    input wire        aclk,
    input wire        aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [4:0]  pin_e_in,
    input wire [4:0]  port_e_gpio_in,
    input wire        serial2_receive_in,
    input wire        serial3_receive_in,
    input wire [7:0]  pin_f_in,
    input wire [7:0]  analog_input_n_sel
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // -----------------------------------------------------------
    // Sequences
    // -----------------------------------------------------------
    // Eight quiet cycles cover the pin synchroniser latency
    sequence e_settled; $stable(pin_e_in) [*8]; endsequence
    sequence f_settled; ($stable(pin_f_in) && $stable(analog_input_n_sel)) [*8]; endsequence
    sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    AST_WR_ANSWER: assert property (wr_taken |=> s_axi_bvalid)
        else $error("write response late");
    AST_WR_BAD_ADDR: assert property (wr_taken ##0 (s_axi_awaddr[1:0] != 2'b00)
        |=> s_axi_bresp == `RESP_SLVERR) else $error("unmapped write not refused");
    AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response late");
    AST_RD_BAD_ADDR: assert property (rd_taken ##0 (s_axi_araddr[1:0] != 2'b00)
        |=> s_axi_rresp == `RESP_SLVERR) else $error("unmapped read not refused");
    AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while response pending");
    AST_GPIO_FOLLOWS: assert property (e_settled |-> port_e_gpio_in == pin_e_in)
        else $error("port input differs from pins");
    AST_RX_LEVEL: assert property (e_settled |->
        (serial2_receive_in == pin_e_in[0] || serial2_receive_in)
        && (serial3_receive_in == pin_e_in[4] || serial3_receive_in))
        else $error("serial receive input neither pin nor idle");
    AST_PORT_F_READ: assert property (f_settled ##0
        (rd_taken ##0 (s_axi_araddr[3:0] == `OFS_F_PIN_DATA))
        |=> s_axi_rdata[7:0] == ($past(pin_f_in) | $past(analog_input_n_sel)))
        else $error("port F read wrong");
endmodule

// *** pin_mux_defs.vh ***
// Constants for the port E function select and port F data read block
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_E_CTRL_1        4'h0
`define OFS_E_CTRL_2        4'h4
`define OFS_F_PIN_DATA      4'h8
`define OFS_E_PIN_LEVEL     4'hC
`define ADDR_DEC_BITS       4

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PIN11_MODE_HI       7
`define PIN11_MODE_LO       6
`define PIN10_MODE_HI       5
`define PIN10_MODE_LO       4
`define PIN9_MODE_HI        3
`define PIN9_MODE_LO        2
`define PIN8_MODE_HI        1
`define PIN8_MODE_LO        0
`define PIN7_MODE_HI        15
`define PIN7_MODE_LO        14

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define E_CTRL_1_RESET      8'h00
`define PIN7_MODE_RESET     2'h0

// ---------------------------------------------------------------
// Mode codes
// ---------------------------------------------------------------
`define MODE_PORT           2'h0
`define MODE_TIMER          2'h1
`define PIN7_SERIAL_CODE    2'h2
`define PIN8_SERIAL_CODE    2'h2
`define PIN9_SERIAL_CODE    2'h3
`define PIN10_SERIAL_CODE   2'h2
`define PIN11_SERIAL_CODE   2'h3

// ---------------------------------------------------------------
// Idle levels fed to a peripheral whose pin is routed elsewhere
// ---------------------------------------------------------------
`define TIMER_IDLE_LEVEL    1'b0
`define SERIAL_IDLE_LEVEL   1'b1

// ---------------------------------------------------------------
// Bus responses
// ---------------------------------------------------------------
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// *** pin_route_cell.v ***
// One multiplexed pin: routes port, timer or serial function to the pin
`timescale 1ns/1ps
`include "pin_mux_defs.vh"

module pin_route_cell #(
    parameter [1:0] SERIAL_CODE = 2'h2
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [1:0] mode,
    input  wire       pin_level,
    input  wire       gpio_out,
    input  wire       gpio_oe,
    input  wire       tio_out,
    input  wire       tio_oe,
    input  wire       ser_out,
    input  wire       ser_oe,
    output reg        pin_out,
    output reg        pin_oe,
    output reg        gpio_in,
    output reg        tio_in,
    output reg        ser_in
);

    // ---------------------------------------------------------------
    // Function decode
    // ---------------------------------------------------------------
    // Prohibited codes fall back to port function
    wire sel_timer  = (mode == `MODE_TIMER);
    wire sel_serial = (mode == SERIAL_CODE);
    reg  out_d;
    reg  oe_d;

    always @* begin
        if (sel_timer) begin
            out_d = tio_out;
            oe_d  = tio_oe;
        end else if (sel_serial) begin
            out_d = ser_out;
            oe_d  = ser_oe;
        end else begin
            out_d = gpio_out;
            oe_d  = gpio_oe;
        end
    end

    // ---------------------------------------------------------------
    // Registered pin drive and peripheral inputs
    // ---------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
            gpio_in <= 1'b0;
            tio_in  <= `TIMER_IDLE_LEVEL;
            ser_in  <= `SERIAL_IDLE_LEVEL;
        end else begin
            pin_out <= out_d;
            pin_oe  <= oe_d;
            // Port always sees the pin, as on a plain port read
            gpio_in <= pin_level;
            // Unselected peripherals see idle, not stray pin activity
            tio_in  <= sel_timer ? pin_level : `TIMER_IDLE_LEVEL;
            ser_in  <= sel_serial ? pin_level : `SERIAL_IDLE_LEVEL;
        end
    end

endmodule

// *** port_e_pin_function_select.v ***
// Port E pin function select with port F data read, AXI4-Lite slave
`timescale 1ns/1ps
`include "pin_mux_defs.vh"

module port_e_pin_function_select (
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite slave
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Port E pins 7..11, bit 0 is pin 7
    input  wire [4:0]  pin_e_in,
    output wire [4:0]  pin_e_out,
    output wire [4:0]  pin_e_oe,
    // Port function of port E pins 7..11
    input  wire [4:0]  port_e_gpio_out,
    input  wire [4:0]  port_e_gpio_oe,
    output wire [4:0]  port_e_gpio_in,
    // Timer pins: ch2 B, ch3 A, ch3 B, ch3 C, ch3 D (bit 0..4)
    input  wire [4:0]  timer_io_out,
    input  wire [4:0]  timer_io_oe,
    output wire [4:0]  timer_io_in,
    // Serial channels
    output wire        serial2_receive_in,
    output wire        serial3_receive_in,
    input  wire        serial2_transmit_out,
    input  wire        serial2_clock_io_out,
    input  wire        serial2_clock_io_oe,
    output wire        serial2_clock_io_in,
    input  wire        serial3_clock_io_out,
    input  wire        serial3_clock_io_oe,
    output wire        serial3_clock_io_in,
    // Port F pins and their analog selection
    input  wire [7:0]  pin_f_in,
    input  wire [7:0]  analog_input_n_sel
);

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    reg  [7:0]  port_e_low_function_ctrl_1_q;
    reg  [1:0]  pin7_mode_q;
    wire [15:0] port_e_low_function_ctrl_2;
    wire [9:0]  pin_modes;

    assign port_e_low_function_ctrl_2 = {pin7_mode_q, 14'h0000};

    // Two bits per pin, pin 7 first
    assign pin_modes = {
        port_e_low_function_ctrl_1_q[`PIN11_MODE_HI:`PIN11_MODE_LO],
        port_e_low_function_ctrl_1_q[`PIN10_MODE_HI:`PIN10_MODE_LO],
        port_e_low_function_ctrl_1_q[`PIN9_MODE_HI:`PIN9_MODE_LO],
        port_e_low_function_ctrl_1_q[`PIN8_MODE_HI:`PIN8_MODE_LO],
        pin7_mode_q
    };

    // ---------------------------------------------------------------
    // Pin input synchronisers
    // ---------------------------------------------------------------
    // Port E in bits 4:0, port F in bits 12:5
    wire [12:0] pin_raw;
    reg  [12:0] sync1_q;
    reg  [12:0] sync2_q;
    reg  [12:0] sync3_q;
    reg  [12:0] level_q;

    assign pin_raw = {pin_f_in, pin_e_in};

    // Data path only; no reset, so levels follow the pins after reset
    always @(posedge aclk) begin
        sync1_q <= pin_raw;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end

    genvar b;
    generate
        for (b = 0; b < 13; b = b + 1) begin : g_filter
            // A change counts once the last two stages agree
            always @(posedge aclk) begin
                if (sync2_q[b] == sync3_q[b]) begin
                    level_q[b] <= sync3_q[b];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Per pin routing
    // ---------------------------------------------------------------
    // Serial code per pin must be constant, it sets each cell's decode
    localparam [9:0] SERIAL_CODES = {`PIN11_SERIAL_CODE, `PIN10_SERIAL_CODE,
                                     `PIN9_SERIAL_CODE, `PIN8_SERIAL_CODE,
                                     `PIN7_SERIAL_CODE};
    wire [4:0] ser_out_v;
    wire [4:0] ser_oe_v;
    wire [4:0] ser_in_v;

    // Receive-only pins never drive; the transmit pin always drives
    assign ser_out_v = {1'b0, serial2_transmit_out, serial3_clock_io_out,
                        serial2_clock_io_out, 1'b0};
    assign ser_oe_v  = {1'b0, 1'b1, serial3_clock_io_oe, serial2_clock_io_oe, 1'b0};

    genvar p;
    generate
        for (p = 0; p < 5; p = p + 1) begin : g_pin
            pin_route_cell #(
                .SERIAL_CODE (SERIAL_CODES[2*p+1:2*p])
            ) u_cell (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .mode      (pin_modes[2*p+1:2*p]),
                .pin_level (level_q[p]),
                .gpio_out  (port_e_gpio_out[p]),
                .gpio_oe   (port_e_gpio_oe[p]),
                .tio_out   (timer_io_out[p]),
                .tio_oe    (timer_io_oe[p]),
                .ser_out   (ser_out_v[p]),
                .ser_oe    (ser_oe_v[p]),
                .pin_out   (pin_e_out[p]),
                .pin_oe    (pin_e_oe[p]),
                .gpio_in   (port_e_gpio_in[p]),
                .tio_in    (timer_io_in[p]),
                .ser_in    (ser_in_v[p])
            );
        end
    endgenerate

    assign serial2_receive_in  = ser_in_v[0];
    assign serial2_clock_io_in = ser_in_v[1];
    assign serial3_clock_io_in = ser_in_v[2];
    assign serial3_receive_in  = ser_in_v[4];

    // ---------------------------------------------------------------
    // Port F read value
    // ---------------------------------------------------------------
    wire [7:0] port_f_pin_data;

    // Analog pins read one so a stray level never leaks through
    assign port_f_pin_data = level_q[12:5] | analog_input_n_sel;

    // ---------------------------------------------------------------
    // Write channel
    // ---------------------------------------------------------------
    reg        aw_held_q;
    reg        w_held_q;
    reg [3:0]  aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;

    wire       aw_take = s_axi_awvalid & s_axi_awready;
    wire       w_take  = s_axi_wvalid & s_axi_wready;
    wire       aw_have = aw_held_q | aw_take;
    wire       w_have  = w_held_q | w_take;
    wire       wr_fire = aw_have & w_have;
    wire [3:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr[3:0];
    wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    wire       wr_map  = (wr_addr == `OFS_E_CTRL_1) | (wr_addr == `OFS_E_CTRL_2) |
                         (wr_addr == `OFS_F_PIN_DATA) | (wr_addr == `OFS_E_PIN_LEVEL);

    // One write in flight: nothing new until the response is taken
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            aw_addr_q    <= 4'h0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr[3:0];
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                aw_held_q <= aw_have;
                w_held_q  <= w_have;
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    // Port F and pin level words are read only; writes answer OKAY
    always @(posedge aclk) begin
        if (!aresetn) begin
            port_e_low_function_ctrl_1_q <= `E_CTRL_1_RESET;
            pin7_mode_q                  <= `PIN7_MODE_RESET;
        end else if (wr_fire) begin
            if (wr_addr == `OFS_E_CTRL_1 && wr_strb[0]) begin
                port_e_low_function_ctrl_1_q <= wr_data[7:0];
            end
            if (wr_addr == `OFS_E_CTRL_2 && wr_strb[1]) begin
                pin7_mode_q <= wr_data[`PIN7_MODE_HI:`PIN7_MODE_LO];
            end
        end
    end

    // ---------------------------------------------------------------
    // Read channel
    // ---------------------------------------------------------------
    reg [31:0] rd_word;
    reg        rd_map;

    always @* begin
        rd_word = 32'h0000_0000;
        rd_map  = 1'b1;
        case (s_axi_araddr[3:0])
            `OFS_E_CTRL_1:    rd_word = {24'h00_0000, port_e_low_function_ctrl_1_q};
            `OFS_E_CTRL_2:    rd_word = {16'h0000, port_e_low_function_ctrl_2};
            `OFS_F_PIN_DATA:  rd_word = {24'h00_0000, port_f_pin_data};
            `OFS_E_PIN_LEVEL: rd_word = {27'h000_0000, level_q[4:0]};
            default:          rd_map  = 1'b0;
        endcase
    end

    // One read in flight: address is refused while data waits
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// *** port_e_pin_function_select_tb.sv ***
// Self-checking bench for the port E function select block
`timescale 1ns/1ps
`include "pin_mux_defs.vh"
module port_e_pin_function_select_tb;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
    logic [31:0] s_axi_araddr = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [4:0]  pin_e_in = 5'h00, port_e_gpio_out = 5'h00, port_e_gpio_oe = 5'h00;
    logic [4:0]  timer_io_out = 5'h00, timer_io_oe = 5'h00;
    logic [4:0]  pin_e_out, pin_e_oe, port_e_gpio_in, timer_io_in;
    logic        serial2_transmit_out = 1'b0, serial2_clock_io_out = 1'b0;
    logic        serial2_clock_io_oe = 1'b0, serial3_clock_io_out = 1'b0;
    logic        serial3_clock_io_oe = 1'b0;
    logic        serial2_receive_in, serial3_receive_in, serial2_clock_io_in, serial3_clock_io_in;
    logic [7:0]  pin_f_in = 8'hA5, analog_input_n_sel = 8'h0F;
    int          failures = 0, n_tests = 0;
    // Function class per pin and code: 0 port, 1 timer, 2 serial drive, 3 serial input
    localparam logic [39:0] CLS = 40'hC4_2484_2434;
    // Legal mode sets only, two bits per pin with pin 7 lowest
    localparam logic [39:0] MODES = {10'h318, 10'h3BA, 10'h155, 10'h000};
    localparam logic [31:0] A_CTRL1 = {28'h000_0000, `OFS_E_CTRL_1};
    localparam logic [31:0] A_CTRL2 = {28'h000_0000, `OFS_E_CTRL_2};
    localparam logic [31:0] A_PORTF = {28'h000_0000, `OFS_F_PIN_DATA};
    localparam logic [31:0] A_LEVEL = {28'h000_0000, `OFS_E_PIN_LEVEL};

    always #2.5 aclk = ~aclk;

    port_e_pin_function_select u_port_e_pin_function_select (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_e_in, .pin_e_out, .pin_e_oe, .port_e_gpio_out,
        .port_e_gpio_oe, .port_e_gpio_in, .timer_io_out, .timer_io_oe, .timer_io_in,
        .serial2_receive_in, .serial3_receive_in, .serial2_transmit_out, .serial2_clock_io_out,
        .serial2_clock_io_oe, .serial2_clock_io_in, .serial3_clock_io_out, .serial3_clock_io_oe,
        .serial3_clock_io_in, .pin_f_in, .analog_input_n_sel);

    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task automatic compare(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    task tally_and_finish;
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Handshakes are judged at the falling edge, where everything has settled
    task automatic check_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_hs, w_hs, b_hs;
        logic [1:0] r;
        b_hs = 1'b0;
        r = 2'b00;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !b_hs; n++) begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (b_hs) s_axi_bready <= 1'b0;
        end
        compare("bvalid", 1'b1, b_hs);
        compare("bresp", er, r);
    endtask

    task automatic check_read(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0] r;
        r_hs = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !r_hs; n++) begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (r_hs) s_axi_rready <= 1'b0;
        end
        compare("rvalid", 1'b1, r_hs);
        compare("rresp", er, r);
        if (er == `RESP_OKAY) compare("rdata", e, d);
    endtask

    // Inverted pattern swaps every drive value so no source hides behind another
    task automatic set_pattern(input logic inv);
        @(posedge aclk);
        port_e_gpio_out <= {5{~inv}};
        port_e_gpio_oe <= {5{inv}};
        timer_io_out <= {5{~inv}};
        timer_io_oe <= {5{~inv}};
        serial2_transmit_out <= inv;
        serial2_clock_io_out <= inv;
        serial2_clock_io_oe <= ~inv;
        serial3_clock_io_out <= inv;
        serial3_clock_io_oe <= ~inv;
        pin_e_in <= {5{inv}};
    endtask

    task automatic check_pins(input logic [9:0] m);
        logic [1:0] k [5];
        logic eo, ev;
        @(negedge aclk);
        for (int p = 0; p < 5; p++) begin
            k[p] = CLS[8*p + 2*m[2*p +: 2] +: 2];
            eo = 1'b0;
            ev = 1'b0;
            case (k[p])
                2'd0: begin
                    eo = port_e_gpio_oe[p];
                    ev = port_e_gpio_out[p];
                end
                2'd1: begin
                    eo = timer_io_oe[p];
                    ev = timer_io_out[p];
                end
                2'd2: begin
                    eo = p == 1 ? serial2_clock_io_oe : p == 2 ? serial3_clock_io_oe : 1'b1;
                    ev = p == 1 ? serial2_clock_io_out
                       : p == 2 ? serial3_clock_io_out : serial2_transmit_out;
                end
                default: ;
            endcase
            compare("pin_oe", eo, pin_e_oe[p]);
            if (eo) compare("pin_out", ev, pin_e_out[p]);
            compare("timer_in", k[p] == 2'd1 ? pin_e_in[p] : 1'b0, timer_io_in[p]);
        end
        compare("gpio_in", pin_e_in, port_e_gpio_in);
        compare("rx2", k[0] == 2'd3 ? pin_e_in[0] : 1'b1, serial2_receive_in);
        compare("serial2_clock_io", k[1] == 2'd2 ? pin_e_in[1] : 1'b1, serial2_clock_io_in);
        compare("serial3_clock_io", k[2] == 2'd2 ? pin_e_in[2] : 1'b1, serial3_clock_io_in);
        compare("rx3", k[4] == 2'd3 ? pin_e_in[4] : 1'b1, serial3_receive_in);
    endtask

    // -----------------------------------------------------------
    // Sequence of tests
    // -----------------------------------------------------------
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        check_read(A_CTRL1, 32'h0000_0000, `RESP_OKAY);
        check_read(A_CTRL2, 32'h0000_0000, `RESP_OKAY);
        check_read(A_PORTF, 32'h0000_00AF, `RESP_OKAY);
        check_write(A_PORTF, 32'h0000_0000, `RESP_OKAY);
        check_read(A_PORTF, 32'h0000_00AF, `RESP_OKAY);
        @(posedge aclk);
        pin_f_in <= 8'h3C;
        analog_input_n_sel <= 8'hC0;
        repeat (8) @(posedge aclk);
        check_read(A_PORTF, 32'h0000_00FC, `RESP_OKAY);
        for (int ps = 0; ps < 2; ps++) begin
            set_pattern(ps[0]);
            for (int c = 0; c < 4; c++) begin
                logic [9:0] m;
                m = MODES[10*c +: 10];
                check_write(A_CTRL1, {24'h00_0000, m[9:2]}, `RESP_OKAY);
                check_write(A_CTRL2, {16'h0000, m[1:0], 14'h0000}, `RESP_OKAY);
                repeat (8) @(posedge aclk);
                check_pins(m);
                check_read(A_CTRL1, {24'h00_0000, m[9:2]}, `RESP_OKAY);
                check_read(A_CTRL2, {16'h0000, m[1:0], 14'h0000}, `RESP_OKAY);
                check_read(A_LEVEL, {27'h000_0000, pin_e_in}, `RESP_OKAY);
            end
        end
        check_write(32'h0000_0002, 32'h0000_0000, `RESP_SLVERR);
        check_read(32'h0000_0002, 32'h0000_0000, `RESP_SLVERR);
        check_read(A_CTRL1, 32'h0000_00C6, `RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        check_read(A_CTRL1, 32'h0000_0000, `RESP_OKAY);
        tally_and_finish;
    end

    // Whole run is a few hundred cycles; this margin only catches a hang
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        tally_and_finish;
    end
endmodule

bind port_e_pin_function_select pin_mux_asserts u_pin_mux_asserts (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_e_in,
    .port_e_gpio_in, .serial2_receive_in, .serial3_receive_in, .pin_f_in, .analog_input_n_sel);
